//--- logic/dds_src_pkg.sv
// constants and types shared by the dds parameter source selector
`default_nettype none
package dds_src_pkg;

  // ********************
  // register map
  // ********************
  localparam logic [7:0] REG_CTRL_ONE     = 8'h00;
  localparam logic [7:0] REG_CTRL_TWO     = 8'h01;
  localparam logic [7:0] REG_MOD_TUNING   = 8'h04;
  localparam logic [7:0] REG_MOD_DENOM    = 8'h05;
  localparam logic [7:0] REG_MOD_NUMER    = 8'h06;
  localparam logic [7:0] REG_RAMP_LOWER   = 8'h07;
  localparam logic [7:0] REG_RAMP_UPPER   = 8'h08;
  localparam logic [7:0] REG_RAMP_RSTEP   = 8'h09;
  localparam logic [7:0] REG_RAMP_FSTEP   = 8'h0a;
  localparam logic [7:0] REG_RAMP_RATE    = 8'h0b;
  localparam logic [7:0] REG_KEY_CTRL     = 8'h0c;
  localparam logic [7:0] REG_RAMP_STATUS  = 8'h0d;
  localparam logic [7:0] REG_PROFILE_BASE = 8'h10;
  localparam int         NUM_REGS         = 13;
  localparam logic [31:0] REG_RESET       = 32'h0000_0000;

  // ********************
  // field positions
  // ********************
  localparam int BIT_KEY_EN      = 8;
  localparam int BIT_KEY_AUTO    = 9;
  localparam int BIT_PROFILE_EN  = 23;
  localparam int BIT_PORT_EN     = 22;
  localparam int BIT_RAMP_EN     = 19;
  localparam int BIT_MOD_EN      = 18;
  localparam int POS_RAMP_DEST   = 20;
  localparam int POS_FALL_RATE   = 16;
  localparam int POS_KEY_TARGET  = 16;
  localparam int POS_PROF_AMP    = 16;
  localparam logic [11:0] AMP_FULL = 12'hfff;

  // ********************
  // timing
  // ********************
  localparam int         SYNC_DIV      = 24;
  localparam logic [4:0] SYNC_LAST     = 5'(SYNC_DIV - 1);
  localparam logic [4:0] SYNC_HIGH_END = 5'(SYNC_DIV / 2);

  typedef enum logic [1:0] {
    DEST_AMP   = 2'b00,
    DEST_PHASE = 2'b01,
    DEST_FREQ  = 2'b10,
    DEST_POLAR = 2'b11
  } dest_t;

  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] phase;
    logic [11:0] amp;
  } param_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  addr;
    logic [31:0] data;
  } prof_wr_t;

endpackage
`default_nettype wire

//--- logic/dds_profile_mem.sv
// eight profile entries, two words each, with registered read
`timescale 1ns/1ps
`default_nettype none
module dds_profile_mem (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // write side
  input  wire dds_src_pkg::prof_wr_t wr,
  // read side
  input  wire logic [2:0]            rd_idx,
  output logic [63:0]                rd_q
);

  typedef struct packed {
    logic [7:0][63:0] mem;
    logic [63:0]      q;
  } mem_state_t;

  mem_state_t st_ff;
  mem_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr.we) begin
      if (wr.addr[0]) begin
        nxt_st.mem[wr.addr[3:1]][63:32] = wr.data;
      end else begin
        nxt_st.mem[wr.addr[3:1]][31:0] = wr.data;
      end
    end
    nxt_st.q = st_ff.mem[rd_idx];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_q = st_ff.q;

endmodule
`default_nettype wire

//--- logic/dds_param_source.sv
// parameter source selection, ramp, keying ramp and modulus accumulator
`timescale 1ns/1ps
`default_nettype none
module dds_param_source (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // register port
  input  wire logic                reg_wr_en,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  output logic [31:0]              reg_rdata,
  input  wire logic                io_update_in,
  // host pins
  input  wire logic [2:0]          profile_select_pins,
  input  wire logic                ramp_direction_in,
  input  wire logic                ramp_hold_in,
  input  wire logic                amplitude_keying,
  input  wire logic [1:0]          function_pins,
  input  wire logic [31:0]         port_data,
  output logic                     sync_clk_out,
  output logic                     ramp_limit_out,
  // synthesis core side
  output dds_src_pkg::param_t      dds_param,
  output logic                     phase_carry_out
);

  typedef struct packed {
    logic [4:0]                 div;
    logic                       sync_clk;
    logic [dds_src_pkg::NUM_REGS-1:0][31:0] buf_regs;
    logic [dds_src_pkg::NUM_REGS-1:0][31:0] act_regs;
    logic [31:0]                ramp_acc;
    logic [15:0]                rate_cnt;
    logic [11:0]                key_acc;
    dds_src_pkg::param_t        param;
    logic                       carry;
    logic                       limit;
    logic [31:0]                rdata;
  } state_t;

  state_t               st_ff;
  state_t               nxt_st;
  dds_src_pkg::prof_wr_t prof_wr;
  logic [63:0]          prof_q;

  // ********************
  // helpers
  // ********************
  // saturating step toward a limit; the ramp parks there instead of wrapping
  function automatic logic [31:0] ramp_step(input logic [31:0] acc, input logic [31:0] step,
                                            input logic [31:0] lim, input logic up);
    logic [32:0] sum;
    sum = '0;
    if (up) begin
      sum = {1'b0, acc} + {1'b0, step};
      ramp_step = (sum >= {1'b0, lim}) ? lim : sum[31:0];
    end else begin
      ramp_step = (acc <= lim || (acc - lim) <= step) ? lim : acc - step;
    end
  endfunction

  function automatic logic [11:0] key_step(input logic [11:0] acc, input logic [11:0] step,
                                           input logic [11:0] lim, input logic up);
    logic [12:0] sum;
    sum = '0;
    if (up) begin
      sum = {1'b0, acc} + {1'b0, step};
      key_step = (sum >= {1'b0, lim}) ? lim : sum[11:0];
    end else begin
      key_step = (acc <= step) ? 12'h000 : acc - step;
    end
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = a < 8'(dds_src_pkg::NUM_REGS);
  endfunction

  // ********************
  // profile storage
  // ********************
  always_comb begin
    prof_wr.we   = reg_wr_en && reg_addr[7:4] == dds_src_pkg::REG_PROFILE_BASE[7:4];
    prof_wr.addr = reg_addr[3:0];
    prof_wr.data = reg_wdata;
  end

  dds_profile_mem u_prof (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wr      (prof_wr),
    .rd_idx  (profile_select_pins),
    .rd_q    (prof_q)
  );

  // ********************
  // decoded controls
  // ********************
  logic        tick;
  logic        key_en, key_auto, prof_en, port_en, ramp_en, mod_en;
  dds_src_pkg::dest_t ramp_dest;
  dds_src_pkg::dest_t port_dest;
  logic [31:0] tuning, denom, numer, lower, upper, rstep, fstep;
  logic [15:0] rise_rate, fall_rate, cur_rate;
  logic [11:0] key_target, key_stepsz;
  logic [31:0] prof_freq;
  logic [15:0] prof_phase;
  logic [11:0] prof_amp;
  logic        ramp_sweep;
  logic [32:0] mod_sum;

  always_comb begin
    tick       = st_ff.div == dds_src_pkg::SYNC_LAST;
    key_en     = st_ff.act_regs[dds_src_pkg::REG_CTRL_ONE][dds_src_pkg::BIT_KEY_EN];
    key_auto   = st_ff.act_regs[dds_src_pkg::REG_CTRL_ONE][dds_src_pkg::BIT_KEY_AUTO];
    prof_en    = st_ff.act_regs[dds_src_pkg::REG_CTRL_TWO][dds_src_pkg::BIT_PROFILE_EN];
    port_en    = st_ff.act_regs[dds_src_pkg::REG_CTRL_TWO][dds_src_pkg::BIT_PORT_EN];
    ramp_en    = st_ff.act_regs[dds_src_pkg::REG_CTRL_TWO][dds_src_pkg::BIT_RAMP_EN];
    mod_en     = st_ff.act_regs[dds_src_pkg::REG_CTRL_TWO][dds_src_pkg::BIT_MOD_EN];
    ramp_dest  = dds_src_pkg::dest_t'(
                 st_ff.act_regs[dds_src_pkg::REG_CTRL_TWO][dds_src_pkg::POS_RAMP_DEST +: 2]);
    port_dest  = dds_src_pkg::dest_t'(function_pins);
    tuning     = st_ff.act_regs[dds_src_pkg::REG_MOD_TUNING];
    denom      = st_ff.act_regs[dds_src_pkg::REG_MOD_DENOM];
    numer      = st_ff.act_regs[dds_src_pkg::REG_MOD_NUMER];
    lower      = st_ff.act_regs[dds_src_pkg::REG_RAMP_LOWER];
    upper      = st_ff.act_regs[dds_src_pkg::REG_RAMP_UPPER];
    rstep      = st_ff.act_regs[dds_src_pkg::REG_RAMP_RSTEP];
    fstep      = st_ff.act_regs[dds_src_pkg::REG_RAMP_FSTEP];
    rise_rate  = st_ff.act_regs[dds_src_pkg::REG_RAMP_RATE][15:0];
    fall_rate  = st_ff.act_regs[dds_src_pkg::REG_RAMP_RATE][dds_src_pkg::POS_FALL_RATE +: 16];
    cur_rate   = ramp_direction_in ? rise_rate : fall_rate;
    key_stepsz = st_ff.act_regs[dds_src_pkg::REG_KEY_CTRL][11:0];
    key_target = st_ff.act_regs[dds_src_pkg::REG_KEY_CTRL][dds_src_pkg::POS_KEY_TARGET +: 12];
    prof_freq  = prof_q[31:0];
    prof_phase = prof_q[47:32];
    prof_amp   = prof_q[32 + dds_src_pkg::POS_PROF_AMP +: 12];
    // modulus mode owns the ramp as an auxiliary accumulator
    ramp_sweep = ramp_en && !mod_en;
    mod_sum    = {1'b0, st_ff.ramp_acc} + {1'b0, numer};
  end

  // ********************
  // next state
  // ********************
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.carry = 1'b0;

    // data clock: high for the first half of each 24-cycle frame
    nxt_st.div      = tick ? 5'h00 : st_ff.div + 5'h01;
    nxt_st.sync_clk = nxt_st.div < dds_src_pkg::SYNC_HIGH_END;

    // register port: writes fill buffers, update copies them in
    if (reg_wr_en && reg_hit(reg_addr) && reg_addr != dds_src_pkg::REG_RAMP_STATUS) begin
      nxt_st.buf_regs[reg_addr[3:0]] = reg_wdata;
    end
    if (io_update_in) begin
      nxt_st.act_regs = nxt_st.buf_regs;
    end
    if (reg_addr == dds_src_pkg::REG_RAMP_STATUS) begin
      nxt_st.rdata = st_ff.ramp_acc;
    end else if (reg_hit(reg_addr)) begin
      nxt_st.rdata = st_ff.buf_regs[reg_addr[3:0]];
    end else begin
      nxt_st.rdata = 32'h0000_0000;
    end

    if (tick) begin
      // ramp or auxiliary accumulator
      if (mod_en) begin
        if (mod_sum >= {1'b0, denom}) begin
          nxt_st.ramp_acc = 32'(mod_sum - {1'b0, denom});
          nxt_st.carry    = 1'b1;
        end else begin
          nxt_st.ramp_acc = mod_sum[31:0];
        end
        nxt_st.rate_cnt = 16'h0000;
      end else if (ramp_en && !ramp_hold_in) begin
        if (st_ff.rate_cnt >= cur_rate) begin
          nxt_st.rate_cnt = 16'h0000;
          nxt_st.ramp_acc = ramp_direction_in
                          ? ramp_step(st_ff.ramp_acc, rstep, upper, 1'b1)
                          : ramp_step(st_ff.ramp_acc, fstep, lower, 1'b0);
        end else begin
          nxt_st.rate_cnt = st_ff.rate_cnt + 16'h0001;
        end
      end

      // keying ramp toward target or zero
      // no manual keying: the pin only steers the automatic ramp
      if (key_en && key_auto) begin
        nxt_st.key_acc = key_step(st_ff.key_acc, key_stepsz, key_target, amplitude_keying);
      end

      // frequency: modulus, ramp, profile, port, stored
      if (mod_en) begin
        nxt_st.param.freq = tuning;
      end else if (ramp_sweep && ramp_dest == dds_src_pkg::DEST_FREQ) begin
        nxt_st.param.freq = st_ff.ramp_acc;
      end else if (prof_en) begin
        nxt_st.param.freq = prof_freq;
      end else if (port_en && port_dest == dds_src_pkg::DEST_FREQ) begin
        nxt_st.param.freq = port_data;
      end else begin
        nxt_st.param.freq = prof_freq;
      end

      // phase
      if (ramp_sweep && ramp_dest == dds_src_pkg::DEST_PHASE) begin
        nxt_st.param.phase = st_ff.ramp_acc[31:16];
      end else if (prof_en) begin
        nxt_st.param.phase = prof_phase;
      end else if (port_en && (port_dest == dds_src_pkg::DEST_PHASE ||
                               port_dest == dds_src_pkg::DEST_POLAR)) begin
        nxt_st.param.phase = port_data[31:16];
      end else begin
        nxt_st.param.phase = prof_phase;
      end

      // amplitude: keying ramp above all
      if (key_en && key_auto) begin
        nxt_st.param.amp = st_ff.key_acc;
      end else if (key_en && ramp_sweep && ramp_dest == dds_src_pkg::DEST_AMP) begin
        nxt_st.param.amp = st_ff.ramp_acc[31:20];
      end else if (key_en && prof_en) begin
        nxt_st.param.amp = prof_amp;
      end else if (port_en && port_dest == dds_src_pkg::DEST_AMP) begin
        nxt_st.param.amp = port_data[31:20];
      end else if (port_en && port_dest == dds_src_pkg::DEST_POLAR) begin
        nxt_st.param.amp = port_data[15:4];
      end else if (key_en) begin
        nxt_st.param.amp = prof_amp;
      end else begin
        nxt_st.param.amp = dds_src_pkg::AMP_FULL;
      end
    end

    nxt_st.limit = ramp_sweep &&
                   (nxt_st.ramp_acc == upper || nxt_st.ramp_acc == lower);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ********************
  // outputs
  // ********************
  assign reg_rdata       = st_ff.rdata;
  assign sync_clk_out    = st_ff.sync_clk;
  assign ramp_limit_out  = st_ff.limit;
  assign dds_param       = st_ff.param;
  assign phase_carry_out = st_ff.carry;

  // ********************
  // checks
  // ********************
  a_sync_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick |-> ##24 tick)
    else $error("data clock period is not 24 cycles");

  a_sync_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick |=> sync_clk_out [*8])
    else $error("data clock not high after frame start");

  a_mod_freq: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && mod_en && !io_update_in |=> dds_param.freq == $past(tuning))
    else $error("modulus mode did not own frequency");

  a_profile_phase: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && prof_en && !(ramp_sweep && ramp_dest == dds_src_pkg::DEST_PHASE)
    |=> dds_param.phase == $past(prof_phase))
    else $error("profile phase not applied on data clock");

  a_amp_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && !key_en && !port_en |=> dds_param.amp == dds_src_pkg::AMP_FULL)
    else $error("amplitude used without keying enable");

  a_key_override: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && key_en && key_auto |=> dds_param.amp == $past(st_ff.key_acc))
    else $error("keying ramp did not override amplitude");

  a_hold_freeze: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && ramp_hold_in && !mod_en |=> $stable(st_ff.ramp_acc))
    else $error("ramp moved while held");

  a_ramp_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && ramp_sweep && ramp_direction_in && !ramp_hold_in && st_ff.ramp_acc == upper
    && !io_update_in |=> st_ff.ramp_acc == $past(upper))
    else $error("ramp left its upper limit");

  a_limit_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ramp_sweep && st_ff.ramp_acc == upper && !io_update_in
    && !(tick && !ramp_direction_in && !ramp_hold_in) |-> ##1 ramp_limit_out)
    else $error("limit output low at limit");

  a_limit_lower: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ramp_sweep && st_ff.ramp_acc == lower && !io_update_in
    && !(tick && ramp_direction_in && !ramp_hold_in) |-> ##1 ramp_limit_out)
    else $error("limit output low at lower limit");

  a_profile_freq: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && prof_en && !mod_en && !(ramp_sweep && ramp_dest == dds_src_pkg::DEST_FREQ)
    |=> dds_param.freq == $past(prof_freq))
    else $error("profile lost frequency to a lower source");

  a_ramp_freq: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && ramp_sweep && ramp_dest == dds_src_pkg::DEST_FREQ
    |=> dds_param.freq == $past(st_ff.ramp_acc))
    else $error("ramp did not drive full frequency word");

  a_ramp_phase: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && ramp_sweep && ramp_dest == dds_src_pkg::DEST_PHASE
    |=> dds_param.phase == $past(st_ff.ramp_acc[31:16]))
    else $error("ramp did not drive phase from its top bits");

  a_polar_split: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && port_en && !prof_en && !ramp_sweep && !key_en
    && port_dest == dds_src_pkg::DEST_POLAR
    |=> dds_param.phase == $past(port_data[31:16]) && dds_param.amp == $past(port_data[15:4]))
    else $error("polar port word not split into phase and amplitude");

  a_carry_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_carry_out |=> !phase_carry_out)
    else $error("carry pulse longer than one cycle");

  a_mod_carry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    phase_carry_out |-> $past(tick) && $past(mod_en) && st_ff.ramp_acc < $past(denom))
    else $error("carry without accumulator wrap");

  a_update_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
    io_update_in && !reg_wr_en |=> st_ff.act_regs == $past(st_ff.buf_regs))
    else $error("update did not load active registers");

  c_mod_carry: cover property (@(posedge clk_sys) disable iff (!rst_n)
    phase_carry_out);
  c_ramp_limit: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(ramp_limit_out));
  c_polar_port: cover property (@(posedge clk_sys) disable iff (!rst_n)
    tick && port_en && port_dest == dds_src_pkg::DEST_POLAR);

  c_key_ramp: cover property (@(posedge clk_sys) disable iff (!rst_n)
    tick && key_en && key_auto && !amplitude_keying);

endmodule
`default_nettype wire

//--- testbench/dds_host_model.sv
// host controller model driving profile pins and parallel port on the data clock
`timescale 1ns/1ps
`default_nettype none
module dds_host_model (
  // clock
  input  wire logic        clk_sys,
  input  wire logic        sync_clk_out,
  // requests from the bench
  input  wire logic [2:0]  req_profile,
  input  wire logic [1:0]  req_func,
  input  wire logic [31:0] req_port,
  // pins towards the device
  output var  logic [2:0]  profile_select_pins,
  output var  logic [1:0]  function_pins,
  output var  logic [31:0] port_data
);
  logic sync_q;

  // ********************
  // pin update just after data clock rise
  // ********************
  // changing right after the rise leaves the whole frame as setup before the next sample
  always @(negedge clk_sys) begin
    sync_q <= sync_clk_out;
    if (sync_clk_out && !sync_q) begin
      profile_select_pins <= req_profile;
      function_pins       <= req_func;
      port_data           <= req_port;
    end
  end
endmodule
`default_nettype wire

//--- testbench/dds_param_source_test.sv
// self-checking bench for the parameter source selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module dds_param_source_test;
  logic clk_sys, rst_n, reg_wr_en, io_update_in, ramp_direction_in, ramp_hold_in;
  logic amplitude_keying, sync_clk_out, ramp_limit_out, phase_carry_out;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, req_port, port_data, rd;
  logic [2:0]  req_profile, profile_select_pins;
  logic [1:0]  req_func, function_pins;
  dds_src_pkg::param_t dds_param;
  int n_errors, tests_run, cnt;

  dds_param_source dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .io_update_in(io_update_in), .profile_select_pins(profile_select_pins),
    .ramp_direction_in(ramp_direction_in), .ramp_hold_in(ramp_hold_in),
    .amplitude_keying(amplitude_keying), .function_pins(function_pins),
    .port_data(port_data), .sync_clk_out(sync_clk_out), .ramp_limit_out(ramp_limit_out),
    .dds_param(dds_param), .phase_carry_out(phase_carry_out));
  dds_host_model host_u (.clk_sys(clk_sys), .sync_clk_out(sync_clk_out),
    .req_profile(req_profile), .req_func(req_func), .req_port(req_port),
    .profile_select_pins(profile_select_pins), .function_pins(function_pins),
    .port_data(port_data));

  always #20 clk_sys = ~clk_sys;

  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] pf(int n);
    pf = 32'h0100_0000 * (n + 1) + n;
  endfunction
  function automatic logic [15:0] pp(int n);
    pp = 16'(16'h1110 * (n + 1));
  endfunction
  function automatic logic [11:0] pa(int n);
    pa = 12'(12'h100 + n);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr_en = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    // idle cycle so a following write never re-raises the strobe in the same step
    @(negedge clk_sys);
  endtask
  task automatic rdreg(input logic [7:0] a);
    reg_addr = a;
    @(negedge clk_sys);
    rd = reg_rdata;
  endtask
  task automatic update();
    io_update_in = 1'b1;
    @(negedge clk_sys);
    io_update_in = 1'b0;
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge sync_clk_out);
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic ctrl(input logic [31:0] c1, input logic [31:0] c2);
    wr(8'h00, c1);
    wr(8'h01, c2);
    update();
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_sync_clock();
    cnt = 0;
    @(posedge sync_clk_out);
    repeat (24) begin
      @(negedge clk_sys);
      if (sync_clk_out === 1'b1) cnt++;
    end
    `CHK("sync high cycles", 12, cnt)
    @(negedge clk_sys);
    `CHK("sync period rise", 1'b1, sync_clk_out)
  endtask
  task automatic t_profiles();
    for (int n = 0; n < 8; n++) begin
      wr(8'h10 + 8'(2 * n), pf(n));
      wr(8'h11 + 8'(2 * n), {4'h0, pa(n), pp(n)});
    end
    ctrl(32'h0000_0000, 32'h0080_0000);
    for (int n = 7; n >= 0; n--) begin
      req_profile = 3'(n);
      frames(2);
      `CHK("profile freq", pf(n), dds_param.freq)
      `CHK("profile phase", pp(n), dds_param.phase)
      `CHK("amp without keying", 12'hfff, dds_param.amp)
    end
    ctrl(32'h0000_0100, 32'h0080_0000);
    frames(2);
    `CHK("profile amp keyed", pa(0), dds_param.amp)
    wr(8'h0c, 32'h0800_0fff);
    ctrl(32'h0000_0300, 32'h0080_0000);
    frames(2);
    `CHK("keying high amp", 12'h800, dds_param.amp)
    amplitude_keying = 1'b0;
    frames(2);
    `CHK("keying low amp", 12'h000, dds_param.amp)
    `CHK("keying keeps freq", pf(0), dds_param.freq)
    amplitude_keying = 1'b1;
  endtask
  task automatic t_port();
    req_profile = 3'h3; req_func = 2'b10; req_port = 32'hdead_beef;
    ctrl(32'h0000_0000, 32'h00c0_0000);
    frames(2);
    `CHK("profile beats port", pf(3), dds_param.freq)
    ctrl(32'h0000_0000, 32'h0040_0000);
    frames(2);
    `CHK("port freq", 32'hdead_beef, dds_param.freq)
    `CHK("stored phase", pp(3), dds_param.phase)
    req_func = 2'b11; req_port = 32'h1234_5678;
    frames(2);
    `CHK("polar phase", 16'h1234, dds_param.phase)
    `CHK("polar amp", 12'h567, dds_param.amp)
    `CHK("polar freq stored", pf(3), dds_param.freq)
    req_func = 2'b00; req_port = 32'h9abc_def0;
    frames(2);
    `CHK("port amp", 12'h9ab, dds_param.amp)
    req_func = 2'b01;
    frames(2);
    `CHK("port phase", 16'h9abc, dds_param.phase)
  endtask
  task automatic t_modulus();
    wr(8'h04, 32'h4ccc_cccc);
    wr(8'h05, 32'h0000_0005);
    wr(8'h06, 32'h0000_0004);
    rdreg(8'h05);
    `CHK("denominator readback", 32'h0000_0005, rd)
    ctrl(32'h0000_0000, 32'h00c4_0000);
    req_func = 2'b10;
    frames(2);
    `CHK("modulus freq", 32'h4ccc_cccc, dds_param.freq)
    `CHK("modulus phase profile", pp(3), dds_param.phase)
    cnt = 0;
    repeat (240) begin
      @(negedge clk_sys);
      if (phase_carry_out === 1'b1) cnt++;
    end
    `CHK("carry pulses", 8, cnt)
  endtask
  task automatic t_ramp();
    wr(8'h07, 32'h0000_0100);
    wr(8'h08, 32'h0000_0400);
    wr(8'h09, 32'h0000_0100);
    wr(8'h0a, 32'h0000_0080);
    wr(8'h0b, 32'h0000_0000);
    ramp_direction_in = 1'b1;
    ctrl(32'h0000_0000, 32'h00a8_0000);
    frames(12);
    `CHK("ramp at upper", 32'h0000_0400, dds_param.freq)
    `CHK("limit at upper", 1'b1, ramp_limit_out)
    `CHK("ramp keeps phase", pp(3), dds_param.phase)
    ramp_hold_in = 1'b1; ramp_direction_in = 1'b0;
    frames(4);
    `CHK("hold freezes", 32'h0000_0400, dds_param.freq)
    ramp_hold_in = 1'b0;
    frames(2);
    `CHK("falling moved", 1'b1, dds_param.freq < 32'h0000_0400)
    `CHK("limit released", 1'b0, ramp_limit_out)
    frames(12);
    `CHK("ramp at lower", 32'h0000_0100, dds_param.freq)
    `CHK("limit at lower", 1'b1, ramp_limit_out)
    wr(8'h0d, 32'hffff_ffff);
    rdreg(8'h0d);
    `CHK("status read only", 32'h0000_0100, rd)
    rdreg(8'h20);
    `CHK("unmapped read", 32'h0000_0000, rd)
    ctrl(32'h0000_0100, 32'h0088_0000);
    frames(2);
    `CHK("ramp amp", 12'h000, dds_param.amp)
    `CHK("ramp spares freq", pf(3), dds_param.freq)
    ctrl(32'h0000_0000, 32'h0098_0000);
    frames(2);
    `CHK("ramp phase", 16'h0000, dds_param.phase)
    `CHK("ramp phase amp full", 12'hfff, dds_param.amp)
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // about 85 frames of traffic; over five times that is a hang
  initial begin
    #(480 * 24 * 40);
    n_errors++;
    give_verdict();
  end

  initial begin
    clk_sys = 1'b0; rst_n = 1'b0; reg_wr_en = 1'b0; io_update_in = 1'b0;
    reg_addr = 8'h00; reg_wdata = 32'h0000_0000; ramp_direction_in = 1'b0;
    ramp_hold_in = 1'b0; amplitude_keying = 1'b1;
    req_profile = 3'h0; req_func = 2'b00; req_port = 32'h0000_0000;
    n_errors = 0; tests_run = 0;
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    t_sync_clock();
    t_profiles();
    t_port();
    t_modulus();
    t_ramp();
    give_verdict();
  end
endmodule
`default_nettype wire
